//--- rtl/alert_routing_map.svh
// Offsets, field positions, reset values and timing counts of the
// alert routing block. Assumes an APB register bus of 8 address bits.
`ifndef ALERT_ROUTING_MAP_SVH
`define ALERT_ROUTING_MAP_SVH

`define ADDR_W              8
`define FIRST_ROUTE_OFF     8'h24
`define SECOND_ROUTE_OFF    8'h28
`define IRQ_STATUS_OFF      8'h30
`define IRQ_MASK_OFF        8'h34

`define ROUTE_W             24
`define ROUTE_RESET         24'h000000
`define FIRST_ROUTE_MASK    24'h00000e
`define SECOND_ROUTE_MASK   24'hfffffe
`define SOURCE_MASK         24'hfffffc
`define BIT_ACC_FULL        3
`define BIT_COUNT_FULL      2
`define BIT_CONV_PULSE      1

`define IRQ_W               3
`define IRQ_CONV            0
`define IRQ_PIN1            1
`define IRQ_PIN2            2
`define IRQ_RESET           3'h0

`define PULSE_TIME_NS       5000
`define CLK_PERIOD_NS       100
`define PULSE_CYCLES        (`PULSE_TIME_NS / `CLK_PERIOD_NS)
`define PULSE_CNT_W         8

`endif

//--- rtl/alert_routing_pkg.sv
// Types shared by the alert routing block.
// Assumes the constants header is on the include path.
`include "alert_routing_map.svh"

package alert_routing_pkg;

  typedef logic [`ROUTE_W-1:0] route_type;
  typedef logic [`IRQ_W-1:0]   irq_type;

  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_FIRST  = 3'b001,
    SEL_SECOND = 3'b010,
    SEL_STATUS = 3'b011,
    SEL_MASK   = 3'b100
  } reg_sel_type;

endpackage : alert_routing_pkg

//--- rtl/alert_pin_routing.sv
// Alert pin routing of a four-channel current and power monitor.
// Assumes an APB master on pclk, condition and enable vectors from
// the measurement core, and pin function bits from elsewhere.
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`include "alert_routing_map.svh"

module alert_pin_routing
  import alert_routing_pkg::*;
#(
  parameter int PULSE_CYCLES = `PULSE_CYCLES
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [`ADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               conv_done,
  input  wire logic [23:0]        alert_src,
  input  wire logic [23:0]        alert_enable,
  input  wire logic               pin1_alert_mode,
  input  wire logic               pin2_alert_mode,
  input  wire logic               pin1_in,
  output logic                    pin1_out,
  output logic                    pin1_oe_n,
  output logic                    slow_sample,
  input  wire logic               gpio_out_req,
  input  wire logic               gpio_oe_n_req,
  output logic                    pin2_out,
  output logic                    pin2_oe_n,
  output logic                    irq
);

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  reg_sel_type              sel;
  route_type                first_route;
  route_type                second_route;
  irq_type                  irq_status;
  irq_type                  irq_mask;
  logic [31:0]              read_value;
  logic                     wr;

  always_comb begin
    sel        = SEL_NONE;
    read_value = 32'h00000000;
    unique case (paddr)
      `FIRST_ROUTE_OFF: begin
        sel        = SEL_FIRST;
        read_value = {8'h00, first_route};
      end
      `SECOND_ROUTE_OFF: begin
        sel        = SEL_SECOND;
        read_value = {8'h00, second_route};
      end
      `IRQ_STATUS_OFF: begin
        sel        = SEL_STATUS;
        read_value = {29'h0, irq_status};
      end
      `IRQ_MASK_OFF: begin
        sel        = SEL_MASK;
        read_value = {29'h0, irq_mask};
      end
      default: begin
        sel        = SEL_NONE;
        read_value = 32'h00000000;
      end
    endcase
  end

  // Zero wait states; read data is caught in the setup cycle
  assign pready  = psel & penable;
  assign pslverr = psel & penable & (sel == SEL_NONE);
  assign wr      = psel & penable & pwrite & (sel != SEL_NONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= read_value;
    end
  end

  // ----------------------------------------
  // Routing registers
  // ----------------------------------------
  // bit 0 never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_route <= `ROUTE_RESET;
    end else if (wr && sel == SEL_FIRST) begin
      first_route <= pwdata[23:0] & `FIRST_ROUTE_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_route <= `ROUTE_RESET;
    end else if (wr && sel == SEL_SECOND) begin
      second_route <= pwdata[23:0] & `SECOND_ROUTE_MASK;
    end
  end

  // ----------------------------------------
  // Conversion-complete pulse timer
  // ----------------------------------------
  // One timer serves both pins so their pulses match exactly
  localparam logic [`PULSE_CNT_W-1:0] PULSE_LOAD = PULSE_CYCLES[`PULSE_CNT_W-1:0];
  logic [`PULSE_CNT_W-1:0]  pulse_cnt;
  logic                     pulse_active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= '0;
    end else if (conv_done) begin
      pulse_cnt <= PULSE_LOAD;
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end
  end

  assign pulse_active = (pulse_cnt != '0);

  // ----------------------------------------
  // Alert combining
  // ----------------------------------------
  // per-source enable vector gates sources
  route_type                live_src;
  logic                     next_alert1;
  logic                     next_alert2;
  logic                     alert1;
  logic                     alert2;

  assign live_src = alert_src & alert_enable & `SOURCE_MASK;

  assign next_alert1 = pin1_alert_mode &
                       ((first_route[`BIT_ACC_FULL] & live_src[`BIT_ACC_FULL]) |
                        (first_route[`BIT_COUNT_FULL] & live_src[`BIT_COUNT_FULL]) |
                        (first_route[`BIT_CONV_PULSE] & pulse_active));

  assign next_alert2 = pin2_alert_mode &
                       ((|(second_route & live_src)) |
                        (second_route[`BIT_CONV_PULSE] & pulse_active));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert1 <= 1'b0;
      alert2 <= 1'b0;
    end else begin
      alert1 <= next_alert1;
      alert2 <= next_alert2;
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Open drain: pulls low while asserted
  assign pin1_out  = 1'b0;
  assign pin1_oe_n = ~alert1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_sample <= 1'b0;
    end else begin
      slow_sample <= pin1_alert_mode ? 1'b0 : pin1_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin2_out  <= 1'b0;
      pin2_oe_n <= 1'b1;
    end else if (pin2_alert_mode) begin
      pin2_out  <= 1'b0;
      pin2_oe_n <= ~next_alert2;
    end else begin
      pin2_out  <= gpio_out_req;
      pin2_oe_n <= gpio_oe_n_req;
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  irq_type                  irq_events;
  irq_type                  irq_clear;

  assign irq_events = {next_alert2 & ~alert2, next_alert1 & ~alert1, conv_done};
  assign irq_clear  = (wr && sel == SEL_STATUS) ? pwdata[`IRQ_W-1:0] : `IRQ_RESET;

  // Set beats a same-cycle clear so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `IRQ_RESET;
    end else if (wr && sel == SEL_MASK) begin
      irq_mask <= pwdata[`IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pulse_load_a: assert property (
    conv_done |=> pulse_cnt == PULSE_LOAD)
    else $error("pulse timer not loaded");

  pulse_quiet_a: assert property (
    !pulse_active && !conv_done |=> !pulse_active)
    else $error("pulse without conversion");

  pin1_mode_a: assert property (
    !pin1_alert_mode |=> pin1_oe_n)
    else $error("first pin driven outside alert mode");

  slow_block_a: assert property (
    pin1_alert_mode |=> slow_sample == 1'b0)
    else $error("slow input seen in alert mode");

  acc_route_a: assert property (
    pin1_alert_mode && first_route[3] && alert_enable[3] && alert_src[3]
    |=> !pin1_oe_n)
    else $error("accumulator alert missing");

  count_route_a: assert property (
    pin1_alert_mode && first_route[2] && alert_enable[2] && alert_src[2]
    |=> !pin1_oe_n)
    else $error("sample count alert missing");

  bit_zero_a: assert property (
    psel && !penable && !pwrite &&
    (paddr == `FIRST_ROUTE_OFF || paddr == `SECOND_ROUTE_OFF) |=> prdata[0] == 1'b0)
    else $error("bit 0 reads nonzero");

  route_write_a: assert property (
    wr && sel == SEL_SECOND |=> second_route == ($past(pwdata[23:0]) & `SECOND_ROUTE_MASK))
    else $error("second routing write lost");

  gpio_pass_a: assert property (
    !pin2_alert_mode |=> pin2_oe_n == $past(gpio_oe_n_req))
    else $error("general purpose drive broken");

  pin2_or_a: assert property (
    pin2_alert_mode && (|(second_route & alert_enable & alert_src & `SOURCE_MASK))
    |=> !pin2_oe_n)
    else $error("routed alert not on second pin");

  cc2_pulse_a: assert property (
    pin2_alert_mode && second_route[1] && conv_done |=> ##1 !pin2_oe_n)
    else $error("second pin conversion pulse missing");

  gated_off_a: assert property (
    pin2_alert_mode && !second_route[1] && !(|(second_route & alert_enable & alert_src))
    |=> pin2_oe_n)
    else $error("second pin asserted without source");

  conv_pulse_c: cover property (
    pin1_alert_mode && first_route[1] && conv_done ##2 !pin1_oe_n);
  pin2_alert_c: cover property (pin2_alert_mode ##1 !pin2_oe_n);
  irq_raise_c: cover property ($rose(irq));
  unmapped_c: cover property (pslverr);

endmodule : alert_pin_routing

//--- testbench/host_pin_monitor.sv
// Host side model of the two shared alert pins.
// Assumes open-drain pins with pull-ups and one pclk domain.
`timescale 1ns/100ps

module host_pin_monitor (
  input  wire logic pclk,
  input  wire logic pin1_out,
  input  wire logic pin1_oe_n,
  input  wire logic pin2_out,
  input  wire logic pin2_oe_n,
  input  wire logic slow_drive,
  output logic      pin1_wire,
  output logic      pin2_wire,
  output logic      pin1_in,
  output int        low1,
  output int        low2
);
  // ----------------------------------------
  // Wire levels
  // ----------------------------------------
  // Released pin floats up, never holds the last value
  assign pin1_wire = (pin1_oe_n ? 1'b1 : pin1_out) & slow_drive;
  assign pin2_wire = pin2_oe_n ? 1'b1 : pin2_out;
  assign pin1_in   = pin1_wire;

  // ----------------------------------------
  // Low time counters
  // ----------------------------------------
  initial begin
    low1 = 0;
    low2 = 0;
  end
  always @(posedge pclk) begin
    if (pin1_wire === 1'b0) low1 <= low1 + 1;
    if (pin2_wire === 1'b0) low2 <= low2 + 1;
  end
endmodule : host_pin_monitor

//--- testbench/tb_top.sv
// Self-checking bench of the alert pin routing block.
// Assumes the map header on the include path and the host pin model.
`timescale 1ns/100ps
`include "alert_routing_map.svh"

module tb_top
  import alert_routing_pkg::*;
;
  localparam int PC = 5;
  logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [`ADDR_W-1:0] paddr = '0;
  logic [31:0]        pwdata = '0, prdata, seed = 32'h4e, r;
  logic               pready, pslverr, conv_done = 0, irq;
  logic               pin1_alert_mode = 0, pin2_alert_mode = 0, slow_drive = 1;
  logic               gpio_out_req = 0, gpio_oe_n_req = 1;
  route_type          alert_src = '0, alert_enable = '0;
  logic               pin1_in, pin1_out, pin1_oe_n, slow_sample;
  logic               pin2_out, pin2_oe_n, pin1_wire, pin2_wire;
  int                 low1, low2, n_errors = 0, num_checks = 0, b, c0, s1, s2;
  logic [31:0]        exp_q[$];
  logic               err_q[$];

  always #50 pclk = ~pclk;

  alert_pin_routing #(.PULSE_CYCLES(PC)) uut (.*);
  host_pin_monitor host (.*);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task tally_and_finish();
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    psel <= 0;
    penable <= 0;
    if (i == 16) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    err_q.push_back(a != `FIRST_ROUTE_OFF && a != `SECOND_ROUTE_OFF &&
                    a != `IRQ_STATUS_OFF && a != `IRQ_MASK_OFF);
    apb(0, a, 0);
  endtask : rd

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // Read data checked where the transfer completes
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      chk(prdata, exp_q.pop_front());
      chk(pslverr, err_q.pop_front());
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(3);
    presetn <= 1;
    rd(`SECOND_ROUTE_OFF, 0);
    rd(`FIRST_ROUTE_OFF, 0);
    rd(`IRQ_MASK_OFF, 0);
    apb(1, `SECOND_ROUTE_OFF, '1);
    rd(`SECOND_ROUTE_OFF, 32'h00fffffe);
    apb(1, `FIRST_ROUTE_OFF, '1);
    rd(`FIRST_ROUTE_OFF, 32'h0000000e);
    apb(1, 8'h3c, '1);
    rd(8'h3c, 0);
    pin1_alert_mode <= 1;
    pin2_alert_mode <= 1;
    alert_enable <= '1;
    for (b = 2; b < 24; b++) begin
      apb(1, `SECOND_ROUTE_OFF, 32'h1 << b);
      r = rnd();
      alert_src <= r[23:0] & ~(24'h1 << b);
      cyc(3);
      chk(pin2_wire, 1);
      alert_src <= r[23:0] | (24'h1 << b);
      cyc(3);
      chk(pin2_wire, 0);
      alert_enable[b] <= 0;
      cyc(3);
      chk(pin2_wire, 1);
      alert_enable[b] <= 1;
    end
    pin2_alert_mode <= 0;
    gpio_oe_n_req <= 0;
    for (c0 = 0; c0 < 2; c0++) begin
      gpio_out_req <= c0[0];
      cyc(3);
      chk(pin2_wire, c0);
    end
    gpio_oe_n_req <= 1;
    for (b = 2; b < 4; b++) begin
      alert_enable <= '0;
      apb(1, `FIRST_ROUTE_OFF, 32'h1 << b);
      alert_enable <= '1;
      alert_src <= 24'h1 << b;
      cyc(3);
      chk(pin1_wire, 0);
      alert_src <= '0;
      cyc(3);
      chk(pin1_wire, 1);
    end
    apb(1, `IRQ_MASK_OFF, 1);
    apb(1, `FIRST_ROUTE_OFF, 2);
    apb(1, `SECOND_ROUTE_OFF, 2);
    for (c0 = 0; c0 < 2; c0++) begin
      pin1_alert_mode <= c0[0];
      pin2_alert_mode <= c0[0];
      cyc(2);
      s1 = low1;
      s2 = low2;
      conv_done <= 1;
      cyc(1);
      conv_done <= 0;
      cyc(PC + 6);
      chk(low1 - s1, c0 * PC);
      chk(low2 - s2, c0 * PC);
    end
    // Conversion event latched, masked in
    chk(irq, 1);
    apb(1, `IRQ_STATUS_OFF, 7);
    cyc(2);
    chk(irq, 0);
    rd(`IRQ_STATUS_OFF, 0);
    cyc(3);
    chk(slow_sample, 0);
    pin1_alert_mode <= 0;
    r = rnd();
    slow_drive <= r[0];
    cyc(3);
    chk(slow_sample, r[0]);
    slow_drive <= !r[0];
    cyc(3);
    chk(slow_sample, !r[0]);
    presetn <= 0;
    cyc(2);
    presetn <= 1;
    rd(`SECOND_ROUTE_OFF, 0);
    tally_and_finish();
  end
endmodule : tb_top
